// ==== lock_mon_cfg.svh ====
// Constants for the lock and reference-loss monitor: register offsets, field positions, resets
// Assumes inclusion by bare name from the monitor's design files
`ifndef LOCK_MON_CFG_SVH
`define LOCK_MON_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define REG_PH_OFFSET     8'h00
`define REG_PH_THRESH     8'h04
`define REG_FR_THRESH     8'h08
`define REG_LOCK_TIMERS   8'h0C
`define REG_LOSS_CTRL     8'h10
`define REG_LOSS_COUNT_A  8'h14
`define REG_LOSS_COUNT_B  8'h18
`define REG_STATUS        8'h1C
`define REG_IRQ_STATUS    8'h20
`define REG_SAMPLE_OUT    8'h24
// ****************************************
// Field positions in the lock timer register
// ****************************************
`define FLD_PH_LOCK_LSB   0
`define FLD_PH_UNLOCK_LSB 8
`define FLD_FR_LOCK_LSB   16
`define FLD_FR_UNLOCK_LSB 24
`define FLD_PDIV_LSB      28
// Loss control: enables in bits 1:0, pin route in bits 5:2 (A) and 9:6 (B)
`define FLD_LOSS_EN_LSB   0
`define FLD_ROUTE_A_LSB   2
`define FLD_ROUTE_B_LSB   6
// Status bit positions
`define BIT_PH_LOCK       0
`define BIT_FR_LOCK       1
`define BIT_LOSS_A        2
`define BIT_LOSS_B        3
// ****************************************
// Reset values
// ****************************************
`define RST_PH_THRESH     32'h0000_0000
`define RST_LOSS_COUNT    16'hFFFF
`define RST_TIMERS        32'h0000_0000
`define LOSS_TICK_DIV     2
`endif

// ==== lock_mon_pkg.sv ====
// Types shared by the lock and reference-loss monitor
// Assumes nothing of its surroundings
package lock_mon_pkg;
  // Lock qualifier state, one-hot
  typedef enum logic [1:0] {
    ST_HUNT   = 2'b01,
    ST_LOCKED = 2'b10
  } lock_state_t;
endpackage

// ==== lock_qualifier.sv ====
// One lock detector: threshold compare, qualification and hysteresis counting
// Assumes a divided loop clock tick from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module lock_qualifier (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_vld_i,      // New detector value
  input wire logic [31:0] magnitude_i, // Absolute value under test
  input wire logic [31:0] threshold_i, // Lock threshold
  input wire logic tick_i,            // Divided loop clock period
  input wire logic [4:0] lock_exp_i,  // Qualification exponent
  input wire logic [2:0] unlock_exp_i, // Unlock exponent
  output logic lock_o
);
  // ****************************************
  // Comparator and qualification counter
  // ****************************************
  logic cmp_ff, nxt_cmp;             // Comparator output, held between samples
  logic [21:0] cnt_ff, nxt_cnt;       // Interval counter
  lock_mon_pkg::lock_state_t st_ff, nxt_st;
  logic [21:0] lock_len;
  logic [21:0] unlock_len;

  assign lock_len = 22'h00_0001 << lock_exp_i;
  assign unlock_len = 22'h00_0002 << unlock_exp_i;
  assign lock_o = (st_ff == lock_mon_pkg::ST_LOCKED);

  // Next state: compare, then count ticks in the qualifying condition
  always_comb begin
    nxt_cmp = cmp_ff;
    nxt_cnt = cnt_ff;
    nxt_st = st_ff;
    if (sample_vld_i) begin
      nxt_cmp = !(magnitude_i > threshold_i);
    end
    case (st_ff)
      lock_mon_pkg::ST_HUNT: begin
        // A false compare restarts qualification
        if (!cmp_ff) begin
          nxt_cnt = 22'h00_0000;
        end else if (tick_i) begin
          if (cnt_ff + 22'h00_0001 >= lock_len) begin
            nxt_st = lock_mon_pkg::ST_LOCKED;
            nxt_cnt = 22'h00_0000;
          end else begin
            nxt_cnt = cnt_ff + 22'h00_0001;
          end
        end
      end
      lock_mon_pkg::ST_LOCKED: begin
        // Held until a long enough false run
        if (cmp_ff) begin
          nxt_cnt = 22'h00_0000;
        end else if (tick_i) begin
          if (cnt_ff + 22'h00_0001 >= unlock_len) begin
            nxt_st = lock_mon_pkg::ST_HUNT;
            nxt_cnt = 22'h00_0000;
          end else begin
            nxt_cnt = cnt_ff + 22'h00_0001;
          end
        end
      end
      default: begin
        nxt_st = lock_mon_pkg::ST_HUNT;
        nxt_cnt = 22'h00_0000;
      end
    endcase
  end

  // Registers; reset clears lock and counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_ff <= 1'b0;
      cnt_ff <= 22'h00_0000;
      st_ff <= lock_mon_pkg::ST_HUNT;
    end else begin
      cmp_ff <= nxt_cmp;
      cnt_ff <= nxt_cnt;
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_unlock_needs_false: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(lock_o) |-> $past(!cmp_ff))
    else $error("lock dropped while comparator true");
  a_lock_needs_true: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(lock_o) |-> $past(cmp_ff) && $past(tick_i))
    else $error("lock rose without true compare on tick");
  a_lock_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_o && cmp_ff |=> lock_o)
    else $error("lock lost while comparator true");
  c_lock_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(lock_o));
  c_lock_fall: cover property (@(posedge clk_i) disable iff (rst_i) $fell(lock_o));
endmodule
`default_nettype wire

// ==== lock_mon.sv ====
// Lock detection and reference-loss monitor with a classic Wishbone register slave
// Assumes phase detector samples on clk_i and references arriving asynchronously on pins
`timescale 1ns/1ns
`default_nettype none
`include "lock_mon_cfg.svh"
module lock_mon (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Phase detector samples
  input wire logic [13:0] phase_sample_i,
  input wire logic phase_sample_vld_i,
  output logic [13:0] loop_sample_o,
  output logic loop_sample_vld_o,
  // References from pins
  input wire logic reference_input_a_i,
  input wire logic reference_input_b_i,
  // Status
  output logic phase_lock_o,
  output logic freq_lock_o,
  output logic [3:0] multipurpose_status_pin_o
);
  // ****************************************
  // Configuration registers
  // ****************************************
  logic [13:0] ph_offset_ff, nxt_ph_offset;     // Signed phase offset
  logic [31:0] ph_thresh_ff, nxt_ph_thresh;     // phase_lock_threshold
  logic [31:0] fr_thresh_ff, nxt_fr_thresh;     // freq_lock_threshold
  logic [31:0] timers_ff, nxt_timers;           // Exponents and divider
  logic [9:0] loss_ctrl_ff, nxt_loss_ctrl;      // Enables and pin routes
  logic [15:0] loss_cnt_a_ff, nxt_loss_cnt_a;   // Terminal count A
  logic [15:0] loss_cnt_b_ff, nxt_loss_cnt_b;   // Terminal count B
  logic [1:0] irq_stat_ff, nxt_irq_stat;        // Sticky loss flags
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic wr_hit;

  // Byte lane merge, used by every writable register except the interrupt status
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // ****************************************
  // Phase offset adder and frequency difference
  // ****************************************
  logic [13:0] sum_ff, nxt_sum;     // Offset sample to the loop
  logic [13:0] prev_ff, nxt_prev;   // Previous sample for difference
  logic vld_ff, nxt_vld;
  logic [31:0] ph_mag, fr_mag;
  logic [14:0] diff;

  always_comb begin
    nxt_sum = sum_ff;
    nxt_prev = prev_ff;
    nxt_vld = phase_sample_vld_i;
    if (phase_sample_vld_i) begin
      // Wraps at 14 bits; software keeps the offset small
      nxt_sum = phase_sample_i + ph_offset_ff;
      nxt_prev = nxt_sum;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum_ff <= 14'h0000;
      prev_ff <= 14'h0000;
      vld_ff <= 1'b0;
    end else begin
      sum_ff <= nxt_sum;
      prev_ff <= nxt_prev;
      vld_ff <= nxt_vld;
    end
  end
  assign loop_sample_o = sum_ff;
  assign loop_sample_vld_o = vld_ff;

  // Magnitudes of the current sample and of the running difference
  assign ph_mag = sum_ff[13] ? 32'(-$signed(sum_ff)) : 32'(sum_ff);
  // Difference against the previous offset sample held for the frequency detector
  assign diff = 15'($signed({nxt_sum[13], nxt_sum}) - $signed({prev_ff[13], prev_ff}));
  assign fr_mag = diff[14] ? 32'(-$signed(diff)) : 32'(diff);

  // ****************************************
  // Divided loop clock
  // ****************************************
  logic [15:0] pdiv_ff, nxt_pdiv;
  logic tick;
  always_comb begin
    nxt_pdiv = pdiv_ff + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) pdiv_ff <= 16'h0000;
    else pdiv_ff <= nxt_pdiv;
  end
  // One tick every 2^P system clocks
  assign tick = ((pdiv_ff & ((16'h0001 << timers_ff[`FLD_PDIV_LSB +: 4]) - 16'h0001)) == 16'h0000);

  // ****************************************
  // Lock detectors
  // ****************************************
  lock_qualifier u_phase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_vld_i(vld_ff),
    .magnitude_i(ph_mag),
    .threshold_i(ph_thresh_ff),
    .tick_i(tick),
    .lock_exp_i(timers_ff[`FLD_PH_LOCK_LSB +: 5]),
    .unlock_exp_i(timers_ff[`FLD_PH_UNLOCK_LSB +: 3]),
    .lock_o(phase_lock_o)
  );
  lock_qualifier u_freq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_vld_i(phase_sample_vld_i),
    .magnitude_i(fr_mag),
    .threshold_i(fr_thresh_ff),
    .tick_i(tick),
    .lock_exp_i(timers_ff[`FLD_FR_LOCK_LSB +: 5]),
    .unlock_exp_i(timers_ff[`FLD_FR_UNLOCK_LSB +: 3]),
    .lock_o(freq_lock_o)
  );

  // ****************************************
  // Reference-loss watchdogs
  // ****************************************
  logic [1:0] ref_s1_ff, ref_s2_ff, ref_s3_ff; // Synchroniser and edge history
  logic half_ff;                               // Advances counters every other clock
  logic [15:0] wd_ff [2];
  logic [15:0] nxt_wd [2];
  logic [1:0] loss_ff, nxt_loss;
  logic [15:0] term [2];
  assign term[0] = loss_cnt_a_ff;
  assign term[1] = loss_cnt_b_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_s1_ff <= 2'h0;
      ref_s2_ff <= 2'h0;
      ref_s3_ff <= 2'h0;
      half_ff <= 1'b0;
    end else begin
      ref_s1_ff <= {reference_input_b_i, reference_input_a_i};
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
      half_ff <= ~half_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_wd
      // A disabled monitor stays cleared; a rising edge restarts the count
      always_comb begin
        nxt_wd[g] = wd_ff[g];
        nxt_loss[g] = loss_ff[g];
        if (!loss_ctrl_ff[`FLD_LOSS_EN_LSB + g]) begin
          nxt_wd[g] = 16'h0000;
          nxt_loss[g] = 1'b0;
        end else if (ref_s2_ff[g] && !ref_s3_ff[g]) begin
          nxt_wd[g] = 16'h0000;
          nxt_loss[g] = 1'b0;
        end else if (half_ff) begin
          if (wd_ff[g] + 16'h0001 >= term[g]) begin
            nxt_loss[g] = 1'b1;
          end else begin
            nxt_wd[g] = wd_ff[g] + 16'h0001;
          end
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          wd_ff[g] <= 16'h0000;
          loss_ff[g] <= 1'b0;
        end else begin
          wd_ff[g] <= nxt_wd[g];
          loss_ff[g] <= nxt_loss[g];
        end
      end
    end
  endgenerate

  // Route each loss flag to the pins selected by its four route bits
  always_comb begin
    multipurpose_status_pin_o = (loss_ctrl_ff[`FLD_ROUTE_A_LSB +: 4] & {4{loss_ff[0]}})
      | (loss_ctrl_ff[`FLD_ROUTE_B_LSB +: 4] & {4{loss_ff[1]}});
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // One wait state keeps read data registered; ack drops the cycle after
  // Writes commit at the edge where the master sees ack, never before it
  assign wr_hit = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i;
  always_comb begin
    nxt_ph_offset = ph_offset_ff;
    nxt_ph_thresh = ph_thresh_ff;
    nxt_fr_thresh = fr_thresh_ff;
    nxt_timers = timers_ff;
    nxt_loss_ctrl = loss_ctrl_ff;
    nxt_loss_cnt_a = loss_cnt_a_ff;
    nxt_loss_cnt_b = loss_cnt_b_ff;
    nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_rdat = 32'h0000_0000;
    // Sticky flags: a write of one clears, a new loss wins over it
    nxt_irq_stat = irq_stat_ff;
    if (wr_hit && wb_adr_i == `REG_IRQ_STATUS && wb_sel_i[0]) begin
      nxt_irq_stat = irq_stat_ff & ~wb_dat_i[`BIT_LOSS_A +: 2];
    end
    nxt_irq_stat = nxt_irq_stat | loss_ff;
    if (wr_hit) begin
      case (wb_adr_i)
        `REG_PH_OFFSET: nxt_ph_offset = 14'(merge({18'h0_0000, ph_offset_ff}, wb_dat_i, wb_sel_i));
        `REG_PH_THRESH: nxt_ph_thresh = merge(ph_thresh_ff, wb_dat_i, wb_sel_i);
        `REG_FR_THRESH: nxt_fr_thresh = merge(fr_thresh_ff, wb_dat_i, wb_sel_i);
        `REG_LOCK_TIMERS: nxt_timers = merge(timers_ff, wb_dat_i, wb_sel_i);
        `REG_LOSS_CTRL: nxt_loss_ctrl = 10'(merge({22'h00_0000, loss_ctrl_ff}, wb_dat_i, wb_sel_i));
        `REG_LOSS_COUNT_A: nxt_loss_cnt_a = 16'(merge({16'h0000, loss_cnt_a_ff}, wb_dat_i, wb_sel_i));
        `REG_LOSS_COUNT_B: nxt_loss_cnt_b = 16'(merge({16'h0000, loss_cnt_b_ff}, wb_dat_i, wb_sel_i));
        default: begin
          // Read-only or unmapped: write ignored, still acknowledged
        end
      endcase
    end
    case (wb_adr_i)
      `REG_PH_OFFSET: nxt_rdat = {18'h0_0000, ph_offset_ff};
      `REG_PH_THRESH: nxt_rdat = ph_thresh_ff;
      `REG_FR_THRESH: nxt_rdat = fr_thresh_ff;
      `REG_LOCK_TIMERS: nxt_rdat = timers_ff;
      `REG_LOSS_CTRL: nxt_rdat = {22'h00_0000, loss_ctrl_ff};
      `REG_LOSS_COUNT_A: nxt_rdat = {16'h0000, loss_cnt_a_ff};
      `REG_LOSS_COUNT_B: nxt_rdat = {16'h0000, loss_cnt_b_ff};
      `REG_STATUS: nxt_rdat = {28'h000_0000, loss_ff, freq_lock_o, phase_lock_o};
      `REG_IRQ_STATUS: nxt_rdat = {28'h000_0000, irq_stat_ff, 2'b00};
      `REG_SAMPLE_OUT: nxt_rdat = {18'h0_0000, sum_ff};
      default: nxt_rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_offset_ff <= 14'h0000;
      ph_thresh_ff <= `RST_PH_THRESH;
      fr_thresh_ff <= `RST_PH_THRESH;
      timers_ff <= `RST_TIMERS;
      loss_ctrl_ff <= 10'h000;
      loss_cnt_a_ff <= `RST_LOSS_COUNT;
      loss_cnt_b_ff <= `RST_LOSS_COUNT;
      irq_stat_ff <= 2'h0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ph_offset_ff <= nxt_ph_offset;
      ph_thresh_ff <= nxt_ph_thresh;
      fr_thresh_ff <= nxt_fr_thresh;
      timers_ff <= nxt_timers;
      loss_ctrl_ff <= nxt_loss_ctrl;
      loss_cnt_a_ff <= nxt_loss_cnt_a;
      loss_cnt_b_ff <= nxt_loss_cnt_b;
      irq_stat_ff <= nxt_irq_stat;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ****************************************
  // Checks
  // ****************************************
  a_offset_added: assert property (@(posedge clk_i) disable iff (rst_i)
    phase_sample_vld_i |=> loop_sample_o == 14'($past(phase_sample_i) + $past(ph_offset_ff)))
    else $error("offset sample mismatch");
  a_loss_sticky_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    loss_ff[0] |=> irq_stat_ff[0])
    else $error("loss not captured in interrupt status");
  a_edge_clears_wd: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_s2_ff[0] && !ref_s3_ff[0] |=> wd_ff[0] == 16'h0000 && !loss_ff[0])
    else $error("watchdog not restarted by edge");
  a_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !loss_ctrl_ff[0] |=> !loss_ff[0])
    else $error("disabled monitor flagged loss");
  // Every pin selected by the B route bits shows a B loss
  a_pin_route: assert property (@(posedge clk_i) disable iff (rst_i)
    loss_ff[1] |-> (multipurpose_status_pin_o & loss_ctrl_ff[`FLD_ROUTE_B_LSB +: 4])
      == loss_ctrl_ff[`FLD_ROUTE_B_LSB +: 4])
    else $error("routed loss missing on pin");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  c_loss_a: cover property (@(posedge clk_i) disable iff (rst_i) $rose(loss_ff[0]));
  c_phase_lock: cover property (@(posedge clk_i) disable iff (rst_i) $rose(phase_lock_o));
  c_freq_lock: cover property (@(posedge clk_i) disable iff (rst_i) $rose(freq_lock_o));
endmodule
`default_nettype wire

// ==== lock_mon_tb.sv ====
// Self-checking bench for the lock detectors and reference-loss monitors
// Assumes the monitor's Wishbone slave acks one cycle after a request and samples are one pulse each
`timescale 1ns/1ns
`default_nettype none
`include "lock_mon_cfg.svh"
// One comparison: counts it, reports a mismatch at once
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module lock_mon_tb;
  // ****************************************
  // Stimulus signals
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF; // Every register is written whole
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [13:0] phase_sample_i = 14'h0000;
  logic phase_sample_vld_i = 1'b0;
  logic [13:0] loop_sample_o;
  logic loop_sample_vld_o;
  logic reference_input_a_i = 1'b0, reference_input_b_i = 1'b0;
  logic phase_lock_o, freq_lock_o;
  logic [3:0] multipurpose_status_pin_o;
  int miscompares = 0, n_tests = 0, cycles = 0, ref_cnt = 0;
  logic ref_a_run = 1'b0; // Reference A toggles only while set
  logic [13:0] offset = 14'h0000; // Offset now programmed
  logic [31:0] rd_q[$]; // Expected read data, oldest first
  logic [13:0] smp_q[$]; // Expected loop samples, oldest first
  logic [31:0] rd_e;
  logic [13:0] smp_e;
  lock_mon lock_mon_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_sample_i(phase_sample_i),
    .phase_sample_vld_i(phase_sample_vld_i), .loop_sample_o(loop_sample_o),
    .loop_sample_vld_o(loop_sample_vld_o), .reference_input_a_i(reference_input_a_i),
    .reference_input_b_i(reference_input_b_i), .phase_lock_o(phase_lock_o),
    .freq_lock_o(freq_lock_o), .multipurpose_status_pin_o(multipurpose_status_pin_o));
  // ****************************************
  // Clock, timeout and reference source
  // ****************************************
  // 25 MHz system clock
  always #20 clk_i = ~clk_i;
  // Cycle ceiling far above the planned run of a few hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // Reference A: rising edge every 10 clocks, well inside a 16-clock watchdog
  always @(posedge clk_i) begin
    if (ref_a_run) begin
      ref_cnt <= (ref_cnt == 4) ? 0 : ref_cnt + 1;
      if (ref_cnt == 4) begin
        reference_input_a_i <= ~reference_input_a_i;
      end
    end
  end
  // ****************************************
  // Output monitor: oldest note against each result
  // ****************************************
  // Read data is judged at the ack edge, while the request still stands
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      rd_e = rd_q.pop_front();
      `CHK(wb_dat_o, rd_e)
    end
    if (loop_sample_vld_o === 1'b1) begin
      smp_e = smp_q.pop_front();
      `CHK(loop_sample_o, smp_e)
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  // Classic single cycle; waits for ack, only the cycle ceiling ends a hang
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wb_read(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb_xfer(1'b0, a, 32'h0000_0000);
  endtask
  // Sample stream: vld stays up across the n samples of one call, then drops for a clock
  task automatic send(input logic [13:0] s, input int n);
    repeat (n) begin
      @(posedge clk_i);
      phase_sample_i <= s;
      phase_sample_vld_i <= 1'b1;
      smp_q.push_back(s + offset); // Wraps at 14 bits
    end
    @(posedge clk_i);
    phase_sample_vld_i <= 1'b0;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(28));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, then an unmapped address reads zero
    wb_read(`REG_PH_THRESH, 32'h0000_0000);
    wb_read(`REG_LOSS_COUNT_A, 32'h0000_FFFF);
    wb_read(`REG_STATUS, 32'h0000_0000);
    wb_read(8'h30, 32'h0000_0000);
    // Offsets at both ends of the allowed range, then one at random
    for (int k = 0; k < 3; k++) begin
      offset = (k == 0) ? 14'h3800 : (k == 1) ? 14'h07FF : 14'(($urandom % 4096) - 2048);
      wb_xfer(1'b1, `REG_PH_OFFSET, {18'h0_0000, offset});
      wb_read(`REG_PH_OFFSET, {18'h0_0000, offset});
      repeat (6) send(14'($urandom), 1);
    end
    offset = 14'h0000;
    wb_xfer(1'b1, `REG_PH_OFFSET, 32'h0000_0000);
    // Thresholds 100 and 20; X=2, Y=1 phase; X=1, Y=0 frequency; P=0
    wb_xfer(1'b1, `REG_PH_THRESH, 32'h0000_0064);
    wb_xfer(1'b1, `REG_FR_THRESH, 32'h0000_0014);
    wb_xfer(1'b1, `REG_LOCK_TIMERS, 32'h0001_0102);
    // Magnitude equal to threshold counts as inside: both lock
    send(14'h0064, 12);
    wb_read(`REG_STATUS, 32'h0000_0003);
    // Two outside samples are shorter than the unlock interval
    send(14'h0065, 2);
    send(14'h0064, 10);
    wb_read(`REG_STATUS, 32'h0000_0003);
    // Alternating +-100: phase stays in, successive difference 200 unlocks frequency
    repeat (6) begin
      send(14'h0064, 1);
      send(14'h3F9C, 1);
    end
    wb_read(`REG_STATUS, 32'h0000_0001);
    // Steady 300: phase unlocks, frequency requalifies on zero difference
    send(14'h012C, 12);
    wb_read(`REG_STATUS, 32'h0000_0002);
    `CHK(phase_lock_o, 1'b0)
    // Last offset sample stays readable between samples
    wb_read(`REG_SAMPLE_OUT, 32'h0000_012C);
    // Watchdogs of 8 ticks; A enabled and routed to pin 0, B routed to pin 2 but off
    wb_xfer(1'b1, `REG_LOSS_COUNT_A, 32'h0000_0008);
    wb_xfer(1'b1, `REG_LOSS_COUNT_B, 32'h0000_0008);
    wb_read(`REG_LOSS_COUNT_A, 32'h0000_0008);
    ref_a_run <= 1'b1;
    wb_xfer(1'b1, `REG_LOSS_CTRL, 32'h0000_0105);
    repeat (60) @(posedge clk_i);
    wb_read(`REG_STATUS, 32'h0000_0002);
    `CHK(multipurpose_status_pin_o, 4'h0)
    // Reference A stops: loss is flagged in status, interrupt status and pin 0
    ref_a_run <= 1'b0;
    repeat (40) @(posedge clk_i);
    // Frequency lock is only trusted together with the loss bits of the same word
    wb_read(`REG_STATUS, 32'h0000_0006);
    wb_read(`REG_IRQ_STATUS, 32'h0000_0004);
    `CHK(multipurpose_status_pin_o, 4'h1)
    // Edges return: live flag clears, sticky copy waits for a write of one
    ref_a_run <= 1'b1;
    repeat (30) @(posedge clk_i);
    wb_read(`REG_STATUS, 32'h0000_0002);
    wb_read(`REG_IRQ_STATUS, 32'h0000_0004);
    wb_xfer(1'b1, `REG_IRQ_STATUS, 32'h0000_0004);
    wb_read(`REG_IRQ_STATUS, 32'h0000_0000);
    // Monitor B enabled with no edges at all: only B reports
    wb_xfer(1'b1, `REG_LOSS_CTRL, 32'h0000_0107);
    repeat (40) @(posedge clk_i);
    wb_read(`REG_STATUS, 32'h0000_000A);
    `CHK(multipurpose_status_pin_o, 4'h4)
    // Reset in mid-run clears locks and loss flags
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_read(`REG_STATUS, 32'h0000_0000);
    `CHK(freq_lock_o, 1'b0)
    repeat (4) @(posedge clk_i);
    stop_test();
  end
endmodule
`default_nettype wire
